// File: hdl/cps_pkg.sv
// Constants for the core status, pointer and power-control register group.
// Assumes a byte-wide special-function register space driven by the core.
package cps_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned PTR_W  = 24;

   // ------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_POWER_CTRL = 8'h87;
   localparam logic [7:0] OFS_STATUS     = 8'hD0;
   localparam logic [7:0] OFS_PTR_LOW    = 8'h82;
   localparam logic [7:0] OFS_PTR_HIGH   = 8'h83;
   localparam logic [7:0] OFS_PTR_PAGE   = 8'h84;

   // Bit addresses of the status word share its upper five bits
   localparam logic [4:0] BIT_BASE_STATUS = 5'h1A;

   // ------------------------------------------------------------
   // Reset and read values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_POWER_CTRL = 8'h00;
   localparam logic [7:0] RST_STATUS     = 8'h00;
   localparam logic [7:0] RST_PTR_BYTE   = 8'h00;
   localparam logic [7:0] UNMAPPED_READ  = 8'h00;

   // ------------------------------------------------------------
   // Status word fields
   // ------------------------------------------------------------
   localparam int unsigned ST_CARRY  = 7;
   localparam int unsigned ST_HALF   = 6;
   localparam int unsigned ST_UF0    = 5;
   localparam int unsigned ST_BANK_H = 4;
   localparam int unsigned ST_BANK_L = 3;
   localparam int unsigned ST_EXCESS = 2;
   localparam int unsigned ST_UF1    = 1;
   localparam int unsigned ST_PARITY = 0;

   // ------------------------------------------------------------
   // Power-control fields
   // ------------------------------------------------------------
   localparam int unsigned PC_RATE2  = 7;
   localparam int unsigned PC_SERWK  = 6;
   localparam int unsigned PC_IRQ0WK = 5;
   localparam int unsigned PC_STBOFF = 4;
   localparam int unsigned PC_SPARE1 = 3;
   localparam int unsigned PC_SPARE0 = 2;
   localparam int unsigned PC_PDOWN  = 1;
   localparam int unsigned PC_SLEEP  = 0;

   // ------------------------------------------------------------
   // Working banks and strobe timing
   // ------------------------------------------------------------
   localparam int unsigned BANK_SHIFT    = 3;   // Eight registers a bank
   localparam logic [2:0]  STROBE_PERIOD = 3'h6; // Oscillator periods
   localparam logic [2:0]  STROBE_LAST   = 3'h5;
   localparam logic [2:0]  STROBE_FIRST  = 3'h0;

endpackage

// File: hdl/cps_pointer.sv
// Three-byte data pointer with a 24-bit increment.
// Assumes write strobes and increment come from the decoder, one clock.
`timescale 1ns/1ps
`default_nettype none

module cps_pointer
(
   input  wire logic  clock,
   input  wire logic  rst_n,
   cps_ptr_if.store   dp
);

   logic [23:0] next_ptr;

   // ------------------------------------------------------------
   // Increment then byte writes
   // ------------------------------------------------------------
   // R2 full carry chain
   always_comb
   begin
      next_ptr = {dp.page, dp.high, dp.low};
      if (dp.inc)
      begin
         next_ptr = next_ptr + 24'h000001;
      end
   end

   // R1 separate byte access; a same-cycle write beats the increment
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dp.page <= cps_pkg::RST_PTR_BYTE;
         dp.high <= cps_pkg::RST_PTR_BYTE;
         dp.low  <= cps_pkg::RST_PTR_BYTE;
      end
      else
      begin
         dp.page <= dp.wr_page ? dp.wdata : next_ptr[23:16];
         dp.high <= dp.wr_high ? dp.wdata : next_ptr[15:8];
         dp.low  <= dp.wr_low  ? dp.wdata : next_ptr[7:0];
      end
   end

endmodule

`default_nettype wire

// File: hdl/cps_ptr_if.sv
// Carrier between the register decoder and the data pointer store.
// Assumes both ends share the single core clock.
`timescale 1ns/1ps
`default_nettype none

interface cps_ptr_if;
   logic       wr_page;
   logic       wr_high;
   logic       wr_low;
   logic [7:0] wdata;
   logic       inc;
   logic [7:0] page;
   logic [7:0] high;
   logic [7:0] low;

   modport ctrl
   (
      output wr_page,
      output wr_high,
      output wr_low,
      output wdata,
      output inc,
      input  page,
      input  high,
      input  low
   );

   modport store
   (
      input  wr_page,
      input  wr_high,
      input  wr_low,
      input  wdata,
      input  inc,
      output page,
      output high,
      output low
   );
endinterface

`default_nettype wire

// File: hdl/cps_regs.sv
// Core status word, data pointer and power-control registers.
// Assumes a synchronous core-side register port on one 20 MHz clock.
//
// Contract
// R1 - Pointer as three bytes or 16-bit pair
// R2 - Pointer increment carries into page byte
// R3 - Status word at D0, reset zero, bit-addressable
// R4 - Status word field layout and bank codes
// R5 - Power control at 87, reset zero, byte-only
// R6 - Power control field layout and meanings
// R7 - All these registers live in register space
// R8 - Unoccupied addresses: no storage, undefined read
// R9 - Software never touches reserved addresses
// R10 - Bank select picks working register bank
// R11 - Latch strobe every six periods, bit stops
// R12 - Parity tracks accumulator, writes ignored
`timescale 1ns/1ps
`default_nettype none

module cps_regs
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic [7:0]  sfr_wdata,
   input  wire logic        sfr_rd,
   output var  logic [7:0]  sfr_rdata,
   output var  logic        sfr_hit,
   input  wire logic        bit_wr,
   input  wire logic [7:0]  bit_addr,
   input  wire logic        bit_wdata,
   input  wire logic [7:0]  acc_value,
   input  wire logic        alu_flag_we,
   input  wire logic        alu_carry,
   input  wire logic        alu_half_carry,
   input  wire logic        alu_excess,
   input  wire logic        ptr_inc,
   input  wire logic        ext_data_access,
   output var  logic [23:0] pointer_24,
   output var  logic [15:0] pointer_16,
   output var  logic [4:0]  work_bank_base,
   output var  logic        uart_rate_double,
   output var  logic        serial_wake_irq_en,
   output var  logic        ext_irq0_wake_en,
   output var  logic        latch_strobe_off,
   output var  logic        spare_flag_one,
   output var  logic        spare_flag_zero,
   output var  logic        power_down_enable,
   output var  logic        sleep_core_enable,
   output var  logic        latch_strobe
);

   // ------------------------------------------------------------
   // Storage and decode
   // ------------------------------------------------------------
   logic [7:0] cpu_status_word;
   logic [7:0] power_ctrl_reg;
   logic [7:0] next_status;
   logic [7:0] next_rdata;
   logic       next_hit;
   logic       hit_status;
   logic       hit_power;
   logic       hit_page;
   logic       hit_high;
   logic       hit_low;
   logic       bit_hit_status;
   logic [2:0] bit_sel;

   cps_ptr_if dp ();

   // R7 register space decode
   assign hit_status = (sfr_addr == cps_pkg::OFS_STATUS);
   assign hit_power  = (sfr_addr == cps_pkg::OFS_POWER_CTRL);
   assign hit_page   = (sfr_addr == cps_pkg::OFS_PTR_PAGE);
   assign hit_high   = (sfr_addr == cps_pkg::OFS_PTR_HIGH);
   assign hit_low    = (sfr_addr == cps_pkg::OFS_PTR_LOW);

   // R3 bit addresses of the status word
   assign bit_hit_status = (bit_addr[7:3] == cps_pkg::BIT_BASE_STATUS);
   assign bit_sel        = bit_addr[2:0];

   // ------------------------------------------------------------
   // Data pointer
   // ------------------------------------------------------------
   // R1 byte write strobes to the pointer store
   assign dp.wr_page = sfr_wr && hit_page;
   assign dp.wr_high = sfr_wr && hit_high;
   assign dp.wr_low  = sfr_wr && hit_low;
   assign dp.wdata   = sfr_wdata;
   // R2 increment of the pair reaches the page byte
   assign dp.inc     = ptr_inc;

   cps_pointer u_pointer
   (
      .clock (clock),
      .rst_n (rst_n),
      .dp    (dp.store)
   );

   // R1 pair and full address straight from the byte flops
   assign pointer_16 = {dp.high, dp.low};
   assign pointer_24 = {dp.page, dp.high, dp.low};

   // ------------------------------------------------------------
   // Status word next value
   // ------------------------------------------------------------
   // Order: byte write, then bit write, then ALU flags, then parity.
   // ALU results win over software so a flag event is never lost.
   always_comb
   begin
      next_status = cpu_status_word;
      // R3 whole-byte write
      if (sfr_wr && hit_status)
      begin
         next_status = sfr_wdata;
      end
      // R3 single bit write
      if (bit_wr && bit_hit_status)
      begin
         next_status[bit_sel] = bit_wdata;
      end
      // R4 carry, half carry and excess from the ALU
      if (alu_flag_we)
      begin
         next_status[cps_pkg::ST_CARRY]  = alu_carry;
         next_status[cps_pkg::ST_HALF]   = alu_half_carry;
         next_status[cps_pkg::ST_EXCESS] = alu_excess;
      end
      // R12 parity always follows the accumulator
      next_status[cps_pkg::ST_PARITY] = ^acc_value;
   end

   // R3 status word reset to zero
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         cpu_status_word <= cps_pkg::RST_STATUS;
      else
         cpu_status_word <= next_status;
   end

   // ------------------------------------------------------------
   // Working bank base
   // ------------------------------------------------------------
   // R10 bank select times eight, in step with the status word
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         work_bank_base <= 5'h00;
      else
         work_bank_base <= {next_status[cps_pkg::ST_BANK_H],
                            next_status[cps_pkg::ST_BANK_L], 3'h0};
   end

   // ------------------------------------------------------------
   // Power control
   // ------------------------------------------------------------
   // R5 byte-only; bit writes never reach this register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         power_ctrl_reg <= cps_pkg::RST_POWER_CTRL;
      else if (sfr_wr && hit_power)
         power_ctrl_reg <= sfr_wdata;
   end

   // R6 field outputs straight from the register
   assign uart_rate_double   = power_ctrl_reg[cps_pkg::PC_RATE2];
   assign serial_wake_irq_en = power_ctrl_reg[cps_pkg::PC_SERWK];
   assign ext_irq0_wake_en   = power_ctrl_reg[cps_pkg::PC_IRQ0WK];
   assign latch_strobe_off   = power_ctrl_reg[cps_pkg::PC_STBOFF];
   assign spare_flag_one     = power_ctrl_reg[cps_pkg::PC_SPARE1];
   assign spare_flag_zero    = power_ctrl_reg[cps_pkg::PC_SPARE0];
   assign power_down_enable  = power_ctrl_reg[cps_pkg::PC_PDOWN];
   assign sleep_core_enable  = power_ctrl_reg[cps_pkg::PC_SLEEP];

   // ------------------------------------------------------------
   // Address latch strobe
   // ------------------------------------------------------------
   // R11 stopped by the power-control bit or a data access
   cps_strobe_gen u_strobe
   (
      .clock      (clock),
      .rst_n      (rst_n),
      .strobe_off (power_ctrl_reg[cps_pkg::PC_STBOFF]),
      .hold_off   (ext_data_access),
      .strobe     (latch_strobe)
   );

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   // R8 unoccupied addresses read a fixed filler and flag no hit
   always_comb
   begin
      next_rdata = cps_pkg::UNMAPPED_READ;
      next_hit   = 1'b1;
      case (sfr_addr)
         cps_pkg::OFS_STATUS:     next_rdata = cpu_status_word;
         cps_pkg::OFS_POWER_CTRL: next_rdata = power_ctrl_reg;
         cps_pkg::OFS_PTR_PAGE:   next_rdata = dp.page;
         cps_pkg::OFS_PTR_HIGH:   next_rdata = dp.high;
         cps_pkg::OFS_PTR_LOW:    next_rdata = dp.low;
         default:                 next_hit   = 1'b0;
      endcase
   end

   // Registered answer one clock after the read strobe; holds otherwise
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sfr_rdata <= cps_pkg::UNMAPPED_READ;
         sfr_hit   <= 1'b0;
      end
      else if (sfr_rd)
      begin
         sfr_rdata <= next_rdata;
         sfr_hit   <= next_hit;
      end
   end

endmodule

`default_nettype wire

// File: hdl/cps_strobe_gen.sv
// Address latch strobe generator, one pulse per six clocks.
// Assumes the clock stands for the oscillator period.
`timescale 1ns/1ps
`default_nettype none

module cps_strobe_gen
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic strobe_off,
   input  wire logic hold_off,
   output var  logic strobe
);

   logic [2:0] phase;

   // ------------------------------------------------------------
   // Free-running phase counter
   // ------------------------------------------------------------
   // Counter keeps running while disabled so re-enable stays in step
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         phase <= cps_pkg::STROBE_FIRST;
      else if (phase == cps_pkg::STROBE_LAST)
         phase <= cps_pkg::STROBE_FIRST;
      else
         phase <= phase + 3'h1;
   end

   // R11 pulse unless disabled
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         strobe <= 1'b0;
      else
         strobe <= (phase == cps_pkg::STROBE_LAST) && !strobe_off
                   && !hold_off;
   end

endmodule

`default_nettype wire

// File: test/cps_core_model.sv
// Core-side model: byte, bit, flag-load and increment requests.
// Assumes the core clock and requests launched on its falling edge.
`timescale 1ns/1ps
`default_nettype none

module cps_core_model
(
   input  wire logic       clock,
   output var  logic [7:0] sfr_addr,
   output var  logic       sfr_wr,
   output var  logic [7:0] sfr_wdata,
   output var  logic       sfr_rd,
   input  wire logic [7:0] sfr_rdata,
   input  wire logic       sfr_hit,
   output var  logic       bit_wr,
   output var  logic [7:0] bit_addr,
   output var  logic       bit_wdata,
   output var  logic       alu_flag_we,
   output var  logic       alu_carry,
   output var  logic       alu_half_carry,
   output var  logic       alu_excess,
   output var  logic       ptr_inc
);
   // Quiet bus at time zero
   initial
   begin
      {sfr_addr, sfr_wdata, bit_addr} = '0;
      {sfr_wr, sfr_rd, bit_wr, alu_flag_we, ptr_inc} = '0;
      {bit_wdata, alu_carry, alu_half_carry, alu_excess} = '0;
   end

   // One request held n cycles; strobes {wr,rd,bit,alu,inc}
   // callers pass only occupied or unused places
   task automatic op(input logic [4:0] s, input logic [7:0] a,
                     input logic [7:0] d, input int n,
                     output logic [7:0] q, output logic h);
      @(negedge clock);
      sfr_addr = a;
      bit_addr = a;
      sfr_wdata = d;
      bit_wdata = d[0];
      {alu_carry, alu_half_carry, alu_excess} = d[2:0];
      {sfr_wr, sfr_rd, bit_wr, alu_flag_we, ptr_inc} = s;
      repeat (n) @(negedge clock);
      {sfr_wr, sfr_rd, bit_wr, alu_flag_we, ptr_inc} = '0;
      // Released qualifiers must not look stable
      sfr_wdata = ~sfr_wdata;
      bit_addr = ~bit_addr;
      q = sfr_rdata;
      h = sfr_hit;
   endtask
endmodule

`default_nettype wire

// File: test/cps_regs_monitor.sv
// Checker for the status, pointer and power-control registers.
// Assumes it is bound to cps_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module cps_regs_monitor
(
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [7:0]  sfr_addr,
   input wire logic        sfr_wr,
   input wire logic [7:0]  sfr_wdata,
   input wire logic        sfr_rd,
   input wire logic [7:0]  sfr_rdata,
   input wire logic        sfr_hit,
   input wire logic        bit_wr,
   input wire logic        ptr_inc,
   input wire logic        ext_data_access,
   input wire logic [23:0] pointer_24,
   input wire logic [15:0] pointer_16,
   input wire logic [4:0]  work_bank_base,
   input wire logic        uart_rate_double,
   input wire logic        serial_wake_irq_en,
   input wire logic        ext_irq0_wake_en,
   input wire logic        latch_strobe_off,
   input wire logic        spare_flag_one,
   input wire logic        spare_flag_zero,
   input wire logic        power_down_enable,
   input wire logic        sleep_core_enable,
   input wire logic        latch_strobe
);
   // ----------------------------------------------------
   // Helpers
   // ----------------------------------------------------
   wire logic [7:0] pc = {uart_rate_double, serial_wake_irq_en,
      ext_irq0_wake_en, latch_strobe_off, spare_flag_one,
      spare_flag_zero, power_down_enable, sleep_core_enable};
   wire logic mapped = sfr_addr inside
      {8'h82, 8'h83, 8'h84, 8'h87, 8'hD0};
   wire logic pc_wr = sfr_wr && sfr_addr == 8'h87;

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_pulse;
      latch_strobe;
   endsequence
   sequence s_quiet;
      !latch_strobe [*5];
   endsequence

   a_pair_view: assert property (
      pointer_16 == pointer_24[15:0])
      else $error("pointer pair differs from low bytes");
   a_ptr_carry: assert property (
      ptr_inc && !sfr_wr |=> pointer_24 == $past(pointer_24) + 24'h1)
      else $error("pointer increment wrong");
   a_bank_base: assert property (
      sfr_wr && sfr_addr == 8'hD0 && !bit_wr
      |=> work_bank_base == {$past(sfr_wdata[4:3]), 3'h0})
      else $error("bank base wrong");
   a_pc_write: assert property (
      pc_wr |=> pc == $past(sfr_wdata))
      else $error("power control not loaded");
   a_pc_hold: assert property (
      !pc_wr |=> $stable(pc))
      else $error("power control changed without byte write");
   a_rd_miss: assert property (
      sfr_rd && !mapped |=> sfr_rdata == 8'h00 && !sfr_hit)
      else $error("unoccupied read not empty");
   a_rd_hit: assert property (
      sfr_rd && mapped |=> sfr_hit)
      else $error("mapped read missed");
   a_strobe_gap: assert property (
      s_pulse |=> s_quiet)
      else $error("strobe pulses too close");
   a_strobe_off: assert property (
      latch_strobe_off || ext_data_access |=> !latch_strobe)
      else $error("strobe while disabled");
endmodule

bind cps_regs cps_regs_monitor i_cps_regs_monitor (.clock, .rst_n,
   .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .sfr_hit,
   .bit_wr, .ptr_inc, .ext_data_access, .pointer_24, .pointer_16,
   .work_bank_base, .uart_rate_double, .serial_wake_irq_en,
   .ext_irq0_wake_en, .latch_strobe_off, .spare_flag_one,
   .spare_flag_zero, .power_down_enable, .sleep_core_enable,
   .latch_strobe);

`default_nettype wire

// File: test/cps_regs_tb_top.sv
// Self-checking bench for the status, pointer and power registers.
// Assumes cps_regs, the core model and the bound checker.
`timescale 1ns/1ps
`default_nettype none

module cps_regs_tb_top;
   logic        clock, rst_n, ext_data_access, hit;
   logic [7:0]  acc_value, rd, a, st, pc;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, bit_addr;
   logic        sfr_wr, sfr_rd, sfr_hit, bit_wr, bit_wdata, ptr_inc;
   logic        alu_flag_we, alu_carry, alu_half_carry, alu_excess;
   logic [23:0] pointer_24, ptr;
   logic [15:0] pointer_16;
   logic [4:0]  work_bank_base;
   logic        uart_rate_double, serial_wake_irq_en, ext_irq0_wake_en;
   logic        latch_strobe_off, spare_flag_one, spare_flag_zero;
   logic        power_down_enable, sleep_core_enable, latch_strobe;
   int          error_cnt, n_checks, cnt, n;
   wire logic [7:0] pc_out = {uart_rate_double, serial_wake_irq_en,
      ext_irq0_wake_en, latch_strobe_off, spare_flag_one,
      spare_flag_zero, power_down_enable, sleep_core_enable};
   logic [7:0] spare_loc [6] = '{8'h9C, 8'h9D, 8'h9E, 8'h9F, 8'hB1,
      8'hF3};

   cps_regs i_cps_regs (.clock, .rst_n, .sfr_addr, .sfr_wr,
      .sfr_wdata, .sfr_rd, .sfr_rdata, .sfr_hit, .bit_wr, .bit_addr,
      .bit_wdata, .acc_value, .alu_flag_we, .alu_carry,
      .alu_half_carry, .alu_excess, .ptr_inc, .ext_data_access,
      .pointer_24, .pointer_16, .work_bank_base, .uart_rate_double,
      .serial_wake_irq_en, .ext_irq0_wake_en, .latch_strobe_off,
      .spare_flag_one, .spare_flag_zero, .power_down_enable,
      .sleep_core_enable, .latch_strobe);
   cps_core_model i_cps_core_model (.clock, .sfr_addr, .sfr_wr,
      .sfr_wdata, .sfr_rd, .sfr_rdata, .sfr_hit, .bit_wr, .bit_addr,
      .bit_wdata, .alu_flag_we, .alu_carry, .alu_half_carry,
      .alu_excess, .ptr_inc);

   // ----------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error at %0t: got %h want %h", $time, g, e);
      end
   endtask

   task automatic tally_and_finish;
      $display("Counts: %0d checks, %0d mismatches", n_checks,
         error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Strobe count, first two cycles skipped to let enables land
   task automatic pulses(input int c);
      repeat (2) @(negedge clock);
      cnt = 0;
      repeat (c) @(negedge clock) cnt += latch_strobe;
   endtask

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // Whole run is well under 2000 cycles
   initial
   begin
      #200us;
      error_cnt++;
      $display("Error at %0t: run hung", $time);
      tally_and_finish();
   end

   // ----------------------------------------------------
   // Tests
   // ----------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      acc_value = 8'h00;
      ext_data_access = 1'b0;
      n = $urandom(50280);
      repeat (5) @(posedge clock);
      @(negedge clock) rst_n = 1'b1;
      // Five occupied places: status, pointer bytes, power control
      for (int i = 0; i < 5; i++)
      begin
         a = (i == 0) ? 8'hD0 : 8'h80 + i[7:0] + 8'h1;
         if (i == 4)
            a = 8'h87;
         i_cps_core_model.op(5'h08, a, 8'h00, 1, rd, hit);
         chk({hit, rd}, 9'h100);
      end
      $display("reset values done");
      for (int i = 0; i < 8; i++)
      begin
         pc = 8'h01 << i;
         i_cps_core_model.op(5'h10, 8'h87, pc, 1, rd, hit);
         chk(pc_out, pc);
         i_cps_core_model.op(5'h04, 8'h80 + i[7:0], ~pc, 1, rd, hit);
         i_cps_core_model.op(5'h08, 8'h87, 8'h00, 1, rd, hit);
         chk({hit, rd}, {1'b1, pc});
      end
      $display("power control done");
      for (int b = 0; b < 4; b++)
      begin
         acc_value = 8'($urandom);
         a = 8'($urandom);
         a[4:3] = b[1:0];
         i_cps_core_model.op(5'h10, 8'hD0, a, 1, rd, hit);
         st = {a[7:1], ^acc_value};
         chk(work_bank_base, b * 8);
         i_cps_core_model.op(5'h08, 8'hD0, 8'h00, 1, rd, hit);
         chk(rd, st);
         i_cps_core_model.op(5'h04, 8'(8'hD0 + b * 2), ~st[b*2], 1, rd, hit);
         if (b != 0)
            st[b*2] = ~st[b*2];
         a = 8'($urandom);
         i_cps_core_model.op(5'h02, 8'h00, a, 1, rd, hit);
         {st[7], st[6], st[2]} = a[2:0];
         i_cps_core_model.op(5'h08, 8'hD0, 8'h00, 1, rd, hit);
         chk(rd, st);
      end
      // Flag load beats a byte write in the same cycle
      a = 8'($urandom);
      i_cps_core_model.op(5'h12, 8'hD0, a, 1, rd, hit);
      st = {a[2:1], a[5:3], a[0], a[1], ^acc_value};
      i_cps_core_model.op(5'h08, 8'hD0, 8'h00, 1, rd, hit);
      chk(rd, st);
      $display("status word done");
      for (int k = 0; k < 4; k++)
      begin
         ptr = (k == 0) ? 24'h00FFFF : (k == 1) ? 24'hFFFFFF : 24'($urandom);
         i_cps_core_model.op(5'h10, 8'h84, ptr[23:16], 1, rd, hit);
         i_cps_core_model.op(5'h10, 8'h83, ptr[15:8], 1, rd, hit);
         i_cps_core_model.op(5'h10, 8'h82, ptr[7:0], 1, rd, hit);
         n = 1 + $urandom % 4;
         i_cps_core_model.op(5'h01, 8'h00, 8'h00, n, rd, hit);
         ptr = ptr + n[23:0];
         chk(pointer_24, ptr);
         chk(pointer_16, ptr[15:0]);
         i_cps_core_model.op(5'h08, 8'h84, 8'h00, 1, rd, hit);
         chk(rd, ptr[23:16]);
      end
      $display("pointer done");
      foreach (spare_loc[i])
      begin
         i_cps_core_model.op(5'h10, spare_loc[i], 8'($urandom), 1, rd, hit);
         i_cps_core_model.op(5'h08, spare_loc[i], 8'h00, 1, rd, hit);
         chk({hit, rd}, 9'h000);
      end
      i_cps_core_model.op(5'h08, 8'hD0, 8'h00, 1, rd, hit);
      chk(rd, st);
      $display("unoccupied places done");
      i_cps_core_model.op(5'h10, 8'h87, 8'h00, 1, rd, hit);
      pulses(60);
      chk(cnt, 10);
      ext_data_access = 1'b1;
      pulses(30);
      chk(cnt, 0);
      ext_data_access = 1'b0;
      i_cps_core_model.op(5'h10, 8'h87, 8'h10, 1, rd, hit);
      pulses(30);
      chk(cnt, 0);
      $display("latch strobe done");
      rst_n = 1'b0;
      @(negedge clock);
      chk({pointer_24, pc_out}, 32'h0);
      rst_n = 1'b1;
      // Registers must answer normally again after a mid-run reset
      i_cps_core_model.op(5'h08, 8'h87, 8'h00, 1, rd, hit);
      chk({hit, rd}, 9'h100);
      i_cps_core_model.op(5'h08, 8'hD0, 8'h00, 1, rd, hit);
      chk({hit, rd}, {1'b1, 7'h00, ^acc_value});
      $display("second reset done");
      tally_and_finish();
   end
endmodule

`default_nettype wire
